// File: rtl/sepa_pkg.sv
/*
 * shared constants for the protected serial eeprom link: instruction
 * opcodes, word sizes, programming time and the host controller's registers.
 * assumes a 40 mhz system clock on both ends.
 */
package sepa_pkg;
   // ==========================================================
   // serial instruction format
   localparam int DATA_W = 16;
   localparam int ADDR_W_DEF = 6;
   localparam logic [1:0] OPC_MISC = 2'h0;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_CLEAR = 2'h3;
   // top two address bits of a misc instruction
   localparam logic [1:0] SUB_ENABLE = 2'h3;
   localparam logic [1:0] SUB_DISABLE = 2'h0;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 4000;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHIFT_BITS = 8;

   // ==========================================================
   // host controller registers
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam int CTRL_CS = 0;
   localparam int CTRL_PROG_EN = 1;
   localparam int CTRL_PROT_ACC = 2;
   localparam int CTRL_RATIO = 3;
   localparam int CTRL_MASTER_SLAVE_SELECT = 5;
   localparam logic [5:0] CTRL_RST = 6'h30;
   localparam int STAT_BUSY = 0;
   localparam int STAT_LINE = 1;
   localparam logic [7:0] BYTE_RST = 8'h00;
endpackage : sepa_pkg

// File: rtl/sepa_link_if.sv
/*
 * three-wire serial link plus chip select and the two enable pins.
 * assumes the host drives every pin except the data-out line, which the
 * eeprom drives only while its enable is high; otherwise it is pulled high.
 */
`timescale 1ns/1ps
interface sepa_link_if;
   logic chip_select;
   logic shift_clock;
   logic eeprom_serial_in;
   logic eeprom_serial_out;
   logic serial_out_oe;
   logic program_enable_pin;
   logic protect_access_pin;
   logic serial_out_line;

   // ==========================================================
   // wire level of the data-out line, pulled high when released
   assign serial_out_line = serial_out_oe ? eeprom_serial_out : 1'b1;

   modport dev(input chip_select, input shift_clock, input eeprom_serial_in,
      input program_enable_pin, input protect_access_pin,
      output eeprom_serial_out, output serial_out_oe);
   modport host(output chip_select, output shift_clock, output eeprom_serial_in,
      output program_enable_pin, output protect_access_pin, input serial_out_line);
endinterface : sepa_link_if

// File: rtl/sepa_host.sv
/*
 * host end: apb-programmed master serial shift port with port-pin lines for
 * chip select and the two enable pins. assumes apb on clk_in and the
 * eeprom end on the link interface.
 */
`timescale 1ns/1ps
module sepa_host (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   sepa_link_if.host link
);
   import sepa_pkg::*;

   logic [5:0] ctrl_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic [2:0] bcnt_q;
   logic [2:0] div_q;
   logic [1:0] ln_q;
   logic [31:0] prdata_q;
   logic busy_q, stop_q, phase_q, sk_q, so_q, pready_q, perr_q;

   // half period of the shift clock in system clocks
   function automatic logic [2:0] half_len(input logic [1:0] sel);
      case (sel)
         2'h0: half_len = 3'h1;
         2'h1: half_len = 3'h2;
         default: half_len = 3'h4;
      endcase
   endfunction : half_len

   // ==========================================================
   // apb decode, one wait state per access
   wire acc = psel_in & penable_in & ~pready_q;
   wire take = psel_in & penable_in & pready_q & pwrite_in;
   wire hit_ctrl = (paddr_in == REG_CTRL);
   wire hit_data = (paddr_in == REG_DATA);
   wire hit_stat = (paddr_in == REG_STAT);
   wire mapped = hit_ctrl | hit_data | hit_stat;
   wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_q} :
                        hit_data ? {24'h0, rx_q} :
                        hit_stat ? {30'h0, ln_q[1], busy_q} : 32'h0;
   wire start = take & hit_stat & pwdata_in[STAT_BUSY] & ~busy_q & ctrl_q[CTRL_MASTER_SLAVE_SELECT];
   wire clear_req = take & hit_stat & ~pwdata_in[STAT_BUSY] & busy_q;
   wire tx_wr = take & hit_data & ~busy_q;
   wire tick = busy_q & (div_q == half_len(ctrl_q[CTRL_RATIO +: 2]) - 3'h1); // RQ11

   // apb answer registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_q <= 1'b0;
         perr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= acc;
         perr_q <= acc & ~mapped;
         prdata_q <= acc ? rd_mux : 32'h0;
      end
   end

   // control register: chip select, enable pins, ratio, master select
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_q <= CTRL_RST;
      end else if (take & hit_ctrl) begin
         ctrl_q <= pwdata_in[5:0]; // RQ5 RQ9 RQ10 RQ23
      end
   end

   // data-out line synchroniser
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ln_q <= 2'h3;
      end else begin
         ln_q <= {ln_q[0], link.serial_out_line}; // RQ18
      end
   end

   // ==========================================================
   // shift engine: msb first, data out set in low half, input taken at rise
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_q <= 1'b0;
         stop_q <= 1'b0;
         phase_q <= 1'b0;
         sk_q <= 1'b0;
         so_q <= 1'b0;
         div_q <= 3'h0;
         bcnt_q <= 3'h0;
         tx_q <= BYTE_RST;
         rx_q <= BYTE_RST;
      end else if (start) begin
         busy_q <= 1'b1; // RQ12
         stop_q <= 1'b0;
         phase_q <= 1'b0;
         div_q <= 3'h0;
         bcnt_q <= 3'h0;
         so_q <= tx_q[7];
      end else if (busy_q) begin
         if (clear_req) begin
            stop_q <= 1'b1; // RQ14
         end
         div_q <= tick ? 3'h0 : div_q + 3'h1;
         if (tick & ~phase_q) begin
            sk_q <= 1'b1;
            phase_q <= 1'b1;
            rx_q <= {rx_q[6:0], ln_q[1]}; // RQ21
            tx_q <= {tx_q[6:0], 1'b0};
         end else if (tick) begin
            sk_q <= 1'b0;
            phase_q <= 1'b0;
            bcnt_q <= bcnt_q + 3'h1;
            so_q <= tx_q[7];
            if (bcnt_q == 3'(SHIFT_BITS - 1) || stop_q || clear_req) begin
               busy_q <= 1'b0; // RQ12 RQ13
            end
         end
      end else if (tx_wr) begin
         tx_q <= pwdata_in[7:0]; // RQ16
      end
   end

   // ==========================================================
   // pins and bus answers
   assign link.chip_select = ctrl_q[CTRL_CS];
   assign link.program_enable_pin = ctrl_q[CTRL_PROG_EN];
   assign link.protect_access_pin = ctrl_q[CTRL_PROT_ACC];
   assign link.shift_clock = sk_q;
   assign link.eeprom_serial_in = so_q;
   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = perr_q;
endmodule : sepa_host

// File: rtl/sepa_device.sv
/*
 * eeprom end: serial eeprom with a protect register, program enable
 * latches, one-time lock and a self-timed programming cycle.
 * assumes link pins arrive asynchronously and are sampled by clk_in.
 */
`timescale 1ns/1ps

// How it works
// RQ1 - program enable pin low blocks all programming
// RQ2 - protect register value splits writable and protected
// RQ3 - addresses at or above protect value refuse writes
// RQ4 - protect access pin low blocks protect changes
// RQ5 - host raises protect access pin for protect ops
// RQ6 - lock instruction freezes protect register for good
// RQ7 - enable instruction opens, disable closes programming
// RQ8 - start bit, opcode, address, data; read 10
// RQ9 - host shift port wired to clock, data lines
// RQ10 - host port runs master, makes the clock
// RQ11 - host clock is system clock over 2/4/8
// RQ12 - host busy bit shifts eight bits, early clear
// RQ13 - host aligns instructions on byte boundaries
// RQ14 - set then clear busy gives one pulse
// RQ15 - longer addresses need two extra alignment bits
// RQ16 - write is start bit plus three bytes
// RQ17 - chip select fall starts the programming cycle
// RQ18 - host checks data-out before next instruction
// RQ19 - data-out rises when programming completes
// RQ20 - read sends dummy zero then data bits
// RQ21 - host takes dummy bit with one pulse
// RQ22 - host logs downward, advancing the protect boundary
// RQ23 - host holds chip select through whole instruction
module sepa_device #(
   parameter int ADDR_W = sepa_pkg::ADDR_W_DEF,
   parameter int PROG_CYCLES = sepa_pkg::PROG_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   sepa_link_if.dev link,
   output logic prog_busy_out,
   output logic locked_out
);
   import sepa_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_HOLD}
      sepa_dev_state_type;
   localparam int TW = $clog2(PROG_CYCLES + 1);

   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic cs_d_q, sk_d_q;
   sepa_dev_state_type state_q;
   logic [4:0] cnt_q;
   logic [1:0] opc_q;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] prot_q;
   logic [DATA_W-1:0] shreg_q;
   logic pre_q, rd_bit_q, wen_q, pren_q, prot_on_q, lock_q, poll_q;
   logic dout_q, doe_q, busy_q;
   logic [TW-1:0] tmr_q;
   logic [DATA_W-1:0] mem [2**ADDR_W];

   // ==========================================================
   // pin synchronisers: chip select, clock, data in, enables
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_q <= 5'h00;
         s2_q <= 5'h00;
         cs_d_q <= 1'b0;
         sk_d_q <= 1'b0;
      end else begin
         s1_q <= {link.chip_select, link.shift_clock, link.eeprom_serial_in,
                  link.program_enable_pin, link.protect_access_pin};
         s2_q <= s1_q;
         cs_d_q <= s2_q[4];
         sk_d_q <= s2_q[3];
      end
   end

   // ==========================================================
   // synced pins, edges and instruction decode
   wire cs_w = s2_q[4];
   wire sk_w = s2_q[3];
   wire din_w = s2_q[2];
   wire pen_w = s2_q[1];
   wire pacc_w = s2_q[0];
   wire sk_rise = sk_w & ~sk_d_q;
   wire cs_fall = ~cs_w & cs_d_q;
   wire busy_w = (tmr_q != '0);
   wire start_bit = cs_w & sk_rise & (state_q == ST_IDLE) & din_w & ~busy_w;
   wire last_addr = (cnt_q == 5'(ADDR_W - 1));
   wire [ADDR_W-1:0] nxt_addr = {addr_q[ADDR_W-2:0], din_w};
   wire [ADDR_W-1:0] inc_addr = addr_q + 1'b1;
   wire [DATA_W-1:0] rd_word = pre_q ? DATA_W'(prot_q) : mem[nxt_addr];
   wire [1:0] sub_w = addr_q[ADDR_W-1 -: 2];
   wire is_misc = (opc_q == OPC_MISC);
   wire commit = cs_fall & (state_q == ST_HOLD) & ~busy_w; // RQ17
   wire pr_ok = pre_q & pacc_w & pren_q & ~lock_q & pen_w; // RQ1 RQ4 RQ6
   wire do_wen = commit & ~pre_q & is_misc & (sub_w == SUB_ENABLE);
   wire do_wds = commit & ~pre_q & is_misc & (sub_w == SUB_DISABLE);
   wire do_pren = commit & pre_q & pacc_w & is_misc & (sub_w == SUB_ENABLE);
   wire do_protect_lock_instr = commit & pr_ok & is_misc & (sub_w == SUB_DISABLE);
   wire do_prclr = commit & pr_ok & (opc_q == OPC_CLEAR) & (&addr_q);
   wire do_prwr = commit & pr_ok & (opc_q == OPC_WRITE);
   wire prot_hit = prot_on_q & (addr_q >= prot_q); // RQ2 RQ3
   wire do_write = commit & ~pre_q & (opc_q == OPC_WRITE) & wen_q & pen_w & ~prot_hit;
   wire start_prog = do_write | do_prwr | do_prclr | do_protect_lock_instr;

   // ==========================================================
   // instruction receiver and read shifter, one step per clock rise
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= ST_IDLE;
         cnt_q <= 5'h00;
         opc_q <= 2'h0;
         addr_q <= '0;
         shreg_q <= '0;
         pre_q <= 1'b0;
         rd_bit_q <= 1'b0;
      end else if (!cs_w) begin
         state_q <= ST_IDLE;
      end else if (sk_rise) begin
         case (state_q)
            ST_IDLE: begin
               if (start_bit) begin
                  state_q <= ST_OPC; // RQ8
                  cnt_q <= 5'h00;
                  pre_q <= pacc_w;
               end
            end
            ST_OPC: begin
               opc_q <= {opc_q[0], din_w};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'h01) begin
                  state_q <= ST_ADDR;
                  cnt_q <= 5'h00;
               end
            end
            ST_ADDR: begin
               addr_q <= nxt_addr;
               cnt_q <= cnt_q + 5'h01;
               if (last_addr) begin
                  cnt_q <= 5'h00;
                  if (opc_q == OPC_READ) begin
                     state_q <= ST_READ;
                     shreg_q <= rd_word;
                     rd_bit_q <= 1'b0; // RQ20
                  end else if (opc_q == OPC_WRITE && !pre_q) begin
                     state_q <= ST_DATA; // RQ8
                  end else begin
                     state_q <= ST_HOLD;
                  end
               end
            end
            ST_DATA: begin
               shreg_q <= {shreg_q[DATA_W-2:0], din_w};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'(DATA_W - 1)) begin
                  state_q <= ST_HOLD;
               end
            end
            ST_READ: begin
               rd_bit_q <= shreg_q[DATA_W-1]; // RQ20
               shreg_q <= {shreg_q[DATA_W-2:0], 1'b0};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'(DATA_W - 1)) begin
                  cnt_q <= 5'h00;
                  addr_q <= inc_addr;
                  shreg_q <= mem[inc_addr];
               end
            end
            ST_HOLD: state_q <= ST_HOLD;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // enable latches, protect register, lock and programming timer
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wen_q <= 1'b0;
         pren_q <= 1'b0;
         prot_on_q <= 1'b0;
         prot_q <= '0;
         lock_q <= 1'b0;
         poll_q <= 1'b0;
         tmr_q <= '0;
      end else begin
         if (do_wen) begin
            wen_q <= 1'b1; // RQ7
         end else if (do_wds) begin
            wen_q <= 1'b0; // RQ7
         end
         if (commit) begin
            pren_q <= do_pren & wen_q; // RQ7
         end
         if (do_prwr) begin
            prot_q <= addr_q; // RQ2
            prot_on_q <= 1'b1;
         end else if (do_prclr) begin
            prot_on_q <= 1'b0;
         end
         if (do_protect_lock_instr) begin
            lock_q <= 1'b1; // RQ6
         end
         if (start_prog) begin
            tmr_q <= TW'(PROG_CYCLES); // RQ17
            poll_q <= 1'b1;
         end else begin
            if (busy_w) begin
               tmr_q <= tmr_q - 1'b1;
            end
            if (start_bit) begin
               poll_q <= 1'b0;
            end
         end
      end
   end

   // array update at the start of the programming cycle
   always_ff @(posedge clk_in) begin
      if (do_write) begin
         mem[addr_q] <= shreg_q; // RQ1 RQ3 RQ17
      end
   end

   // ==========================================================
   // data-out: read bits, or ready status while selected after a program
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dout_q <= 1'b0;
         doe_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         doe_q <= cs_w & ((state_q == ST_READ) | ((state_q == ST_IDLE) & poll_q));
         dout_q <= (state_q == ST_READ) ? rd_bit_q : ~busy_w; // RQ19 RQ20
         busy_q <= busy_w;
      end
   end

   assign link.eeprom_serial_out = dout_q;
   assign link.serial_out_oe = doe_q;
   assign prog_busy_out = busy_q;
   assign locked_out = lock_q;
endmodule : sepa_device

// File: bench/sepa_chk.sv
/*
 * checker for the serial link joining host and eeprom ends.
 * assumes link signals and device status outputs all run on clk_in.
 */
`timescale 1ns/1ps
module sepa_chk #(
   parameter int PROG_CYCLES = 160
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic chip_select,
   input wire logic shift_clock,
   input wire logic eeprom_serial_in,
   input wire logic eeprom_serial_out,
   input wire logic serial_out_oe,
   input wire logic program_enable_pin,
   input wire logic protect_access_pin,
   input wire logic prog_busy_out,
   input wire logic locked_out
);
   // ==========================================================
   // helper counters: ages since select fall and pin lows, run lengths
   logic cs_prev_q;
   logic [4:0] fall_age_q, prog_low_q, prot_low_q;
   logic [15:0] busy_len_q;
   logic [2:0] hi_len_q;
   wire cs_fell = cs_prev_q && !chip_select;
   wire [4:0] fall_inc = fall_age_q + {4'h0, fall_age_q != 5'h1f};
   wire [4:0] prog_inc = prog_low_q + {4'h0, prog_low_q != 5'h1f};
   wire [4:0] prot_inc = prot_low_q + {4'h0, prot_low_q != 5'h1f};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cs_prev_q <= 1'b0;
         fall_age_q <= 5'h1f;
         prog_low_q <= 5'h1f;
         prot_low_q <= 5'h1f;
         busy_len_q <= 16'h0;
         hi_len_q <= 3'h0;
      end else begin
         cs_prev_q <= chip_select;
         fall_age_q <= cs_fell ? 5'h0 : fall_inc;
         prog_low_q <= program_enable_pin ? 5'h0 : prog_inc;
         prot_low_q <= protect_access_pin ? 5'h0 : prot_inc;
         busy_len_q <= prog_busy_out ? busy_len_q + 16'h1 : 16'h0;
         hi_len_q <= shift_clock ? hi_len_q + 3'h1 : 3'h0;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   property p_release;
      (!chip_select)[*6] |-> !serial_out_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("data-out driven while deselected");
   property p_busy_len;
      $fell(prog_busy_out) |-> busy_len_q >= PROG_CYCLES - 1 && busy_len_q <= PROG_CYCLES + 1;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("programming cycle length wrong");
   property p_busy_cause;
      $rose(prog_busy_out) |-> fall_age_q <= 5'ha;
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("programming began without a select fall");
   property p_done_edge;
      serial_out_oe && chip_select && $rose(eeprom_serial_out) |-> ##[0:2] !prog_busy_out;
   endproperty
   a_done_edge: assert property (p_done_edge)
      else $error("data-out rose while still programming");
   property p_prog_gate;
      $rose(prog_busy_out) |-> prog_low_q < 5'h8;
   endproperty
   a_prog_gate: assert property (p_prog_gate)
      else $error("programming with enable pin low");
   property p_lock_sticky;
      locked_out |=> locked_out;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock released");
   property p_lock_cause;
      $rose(locked_out) |-> prot_low_q < 5'h8;
   endproperty
   a_lock_cause: assert property (p_lock_cause)
      else $error("lock set with protect access low");
   property p_clk_high;
      $fell(shift_clock) |-> hi_len_q == 3'h1 || hi_len_q == 3'h2 || hi_len_q == 3'h4;
   endproperty
   a_clk_high: assert property (p_clk_high)
      else $error("shift clock high phase not 1, 2 or 4");
   property p_data_hold;
      shift_clock && $past(shift_clock) |-> $stable(eeprom_serial_in);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("serial data moved while clock high");
endmodule : sepa_chk

// File: bench/tb_serial_eeprom_protect_access.sv
/*
 * testbench: apb-driven host talking to the eeprom end over the link.
 * assumes the package constants and a 40 mhz clk_in.
 */
`timescale 1ns/1ps
module tb_serial_eeprom_protect_access;
   import sepa_pkg::*;
   localparam int PROG = 40;
   logic clk_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd_q;
   logic prog_busy_out, locked_out, slverr_q, en_q, acc_q, zs_q;
   logic [1:0] ratio_q;
   logic [15:0] w;
   logic [5:0] adr [5] = '{6'h05, 6'h06, 6'h0f, 6'h10, 6'h14};
   logic [15:0] dat [5] = '{16'ha5c3, 16'h1111, 16'h0f0f, 16'h1616, 16'hbeef};
   int failures, tests_run, cycles;

   // ==========================================================
   // both ends, the link and the checker
   sepa_link_if link();
   sepa_host u_sepa_host(.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .link(link));
   sepa_device #(.ADDR_W(ADDR_W_DEF), .PROG_CYCLES(PROG)) u_sepa_device(.clk_in(clk_in),
      .resetn_in(resetn_in), .link(link), .prog_busy_out(prog_busy_out),
      .locked_out(locked_out));
   sepa_chk #(.PROG_CYCLES(PROG)) u_sepa_chk(.clk_in(clk_in), .resetn_in(resetn_in),
      .chip_select(link.chip_select), .shift_clock(link.shift_clock),
      .eeprom_serial_in(link.eeprom_serial_in), .eeprom_serial_out(link.eeprom_serial_out),
      .serial_out_oe(link.serial_out_oe), .program_enable_pin(link.program_enable_pin),
      .protect_access_pin(link.protect_access_pin), .prog_busy_out(prog_busy_out),
      .locked_out(locked_out));

   // ==========================================================
   // clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         give_verdict();
      end
   end

   // ==========================================================
   // tasks
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one apb transfer, held until pready, then one idle edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= addr;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) begin
         @(posedge clk_in);
      end
      rd_q = prdata_out;
      slverr_q = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask : apb
   task automatic ctrl(input logic cs);
      apb(1'b1, REG_CTRL, {26'h0, 1'b1, ratio_q, acc_q, en_q, cs});
   endtask : ctrl
   task automatic wait_idle();
      for (int i = 0; i < 100; i++) begin
         apb(1'b0, REG_STAT, 32'h0);
         if (rd_q[STAT_BUSY] === 1'b0) break;
      end
   endtask : wait_idle
   task automatic shift8(input logic [7:0] b);
      apb(1'b1, REG_DATA, {24'h0, b});
      apb(1'b1, REG_STAT, 32'h1);
      wait_idle();
   endtask : shift8
   // lone clock pulse by starting then stopping the shifter
   task automatic pulse(input logic b);
      apb(1'b1, REG_DATA, {24'h0, b, 7'h0});
      apb(1'b1, REG_STAT, 32'h1);
      apb(1'b1, REG_STAT, 32'h0);
      wait_idle();
   endtask : pulse
   // instruction, commit by deselect, then poll the data-out line
   task automatic cmd(input logic acc, input logic acc_end, input logic [1:0] op,
         input logic [5:0] a, input logic has_d, input logic [15:0] d, input logic bsy);
      acc_q = acc;
      ratio_q = 2'h1;
      ctrl(1'b1);
      // a lone pulse needs /4 or slower: the stop write lands four clocks after the start
      if (zs_q) shift8(8'h01);
      else pulse(1'b1);
      ratio_q = 2'h0;
      ctrl(1'b1);
      shift8({op, a});
      if (has_d) begin
         shift8(d[15:8]);
         shift8(d[7:0]);
      end
      acc_q = acc_end;
      ctrl(1'b0);
      ctrl(1'b1);
      // first status read can predate the reselect reaching the eeprom end
      apb(1'b0, REG_STAT, 32'h0);
      apb(1'b0, REG_STAT, 32'h0);
      if (bsy) check("line while busy", 32'h0, {31'h0, rd_q[STAT_LINE]});
      for (int i = 0; i < 60 && rd_q[STAT_LINE] !== 1'b1; i++) apb(1'b0, REG_STAT, 32'h0);
      check("line done", 32'h1, {31'h0, rd_q[STAT_LINE]});
      ctrl(1'b0);
   endtask : cmd
   task automatic rdw(input logic acc, input logic [5:0] a);
      acc_q = acc;
      ratio_q = 2'h2;
      ctrl(1'b1);
      pulse(1'b1);
      shift8({OPC_READ, a});
      pulse(1'b0);
      apb(1'b0, REG_DATA, 32'h0);
      check("dummy bit", 32'h0, {31'h0, rd_q[0]});
      shift8(8'h00);
      apb(1'b0, REG_DATA, 32'h0);
      w[15:8] = rd_q[7:0];
      shift8(8'h00);
      apb(1'b0, REG_DATA, 32'h0);
      w[7:0] = rd_q[7:0];
      ctrl(1'b0);
   endtask : rdw
   task automatic wen();
      cmd(1'b0, 1'b0, OPC_MISC, {SUB_ENABLE, 4'h0}, 1'b0, 16'h0, 1'b0);
   endtask : wen
   task automatic wr_rd(input logic [5:0] a, input logic [15:0] d, input logic [15:0] exp,
         input logic bsy);
      cmd(1'b0, 1'b0, OPC_WRITE, a, 1'b1, d, bsy);
      rdw(1'b0, a);
      check("word", {16'h0, exp}, {16'h0, w});
   endtask : wr_rd

   // ==========================================================
   // main sequence
   initial begin
      {psel_in, penable_in, pwrite_in, en_q, acc_q} = 5'h0;
      paddr_in = 8'h0;
      pwdata_in = 32'h0;
      ratio_q = 2'h0;
      zs_q = 1'b0;
      resetn_in = 1'b0;
      repeat (10) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl reset", {26'h0, CTRL_RST}, rd_q);
      apb(1'b0, 8'h0c, 32'h0);
      check("unmapped", 32'h1, {31'h0, slverr_q});
      en_q = 1'b1;
      wen();
      for (int i = 0; i < 5; i++) wr_rd(adr[i], dat[i], dat[i], 1'b1);
      en_q = 1'b0;
      wr_rd(adr[0], 16'h1234, dat[0], 1'b0);
      en_q = 1'b1;
      wen();
      cmd(1'b0, 1'b0, OPC_MISC, {SUB_DISABLE, 4'h0}, 1'b0, 16'h0, 1'b0);
      wr_rd(adr[1], 16'h2222, dat[1], 1'b0);
      wen();
      cmd(1'b1, 1'b1, OPC_MISC, {SUB_ENABLE, 4'h0}, 1'b0, 16'h0, 1'b0);
      cmd(1'b1, 1'b0, OPC_WRITE, 6'h10, 1'b0, 16'h0, 1'b0);
      wr_rd(6'h14, 16'h0bad, 16'h0bad, 1'b1);
      cmd(1'b1, 1'b1, OPC_MISC, {SUB_ENABLE, 4'h0}, 1'b0, 16'h0, 1'b0);
      cmd(1'b1, 1'b1, OPC_WRITE, 6'h10, 1'b0, 16'h0, 1'b1);
      zs_q = 1'b1;
      wr_rd(6'h0f, 16'h5a5a, 16'h5a5a, 1'b1);
      zs_q = 1'b0;
      wr_rd(6'h10, 16'h6161, dat[3], 1'b0);
      wr_rd(6'h14, 16'h7777, 16'h0bad, 1'b0);
      rdw(1'b1, 6'h0);
      check("protect value", 32'h10, {26'h0, w[5:0]});
      cmd(1'b1, 1'b1, OPC_MISC, {SUB_ENABLE, 4'h0}, 1'b0, 16'h0, 1'b0);
      cmd(1'b1, 1'b1, OPC_MISC, {SUB_DISABLE, 4'h0}, 1'b0, 16'h0, 1'b1);
      check("locked", 32'h1, {31'h0, locked_out});
      cmd(1'b1, 1'b1, OPC_MISC, {SUB_ENABLE, 4'h0}, 1'b0, 16'h0, 1'b0);
      cmd(1'b1, 1'b1, OPC_CLEAR, 6'h3f, 1'b0, 16'h0, 1'b0);
      rdw(1'b1, 6'h0);
      check("protect kept", 32'h10, {26'h0, w[5:0]});
      wr_rd(6'h14, 16'h8888, 16'h0bad, 1'b0);
      give_verdict();
   end
endmodule : tb_serial_eeprom_protect_access
